// ---- hw/spmsfp_top.v ----
// Serial port top: APB registers, master/slave shift engine, framing
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "spmsfp_defines.vh"

// Behaviour
// - Data moves through a 16-bit shift register; software uses a buffer register
// - Master drives shift clock pin; slave takes it as input
// - Enable bit 15 of status register turns the port and its pins on
// - Stop-in-idle bit 13 halts the port while device is idle
// - New word while previous unread is discarded and overflow bit 6 set
// - Transmit full bit 1 set on buffer write, cleared on shift load
// - Receive full bit 0 set on receive, cleared on buffer read
// - Clock disable bit 12 stops master clock and releases clock pin
// - Output disable bit 11 releases the serial output pin
// - Word width bit picks 16-bit or 8-bit transfers
// - Master samples input at end of bit when bit 9 set, else middle; when output changes entering active, the last bit is always taken at middle
// - Outside framed mode, clock edge bit 8 picks whether output changes leaving or entering active
// - Select enable bit 7 makes slave obey the select pin
// - Polarity bit 6 set gives idle-high clock, clear gives idle-low
// - Master select bit 5 picks master or slave
// - Framed bit 15 of control two turns select pin into frame sync
// - Frame sync direction bit 14 set takes sync as input, clear drives it
// - Frame sync polarity bit 13 set gives active-high sync
// - Frame sync edge bit 1 set aligns sync with first bit, else before
module spmsfp_top (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Device power state
    input  wire        device_idle,
    // Shift clock pin
    input  wire        shift_clock_pin_i,
    output wire        shift_clock_pin_o,
    output wire        shift_clock_pin_oe,
    // Serial data pins
    input  wire        serial_in_pin,
    output wire        serial_out_pin_o,
    output wire        serial_out_pin_oe,
    // Select / frame sync pin
    input  wire        select_pin_n_i,
    output wire        select_pin_n_o,
    output wire        select_pin_n_oe
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_PRE   = 2'h1;
    localparam [1:0] ST_SHIFT = 2'h2;
    localparam [15:0] RST_STAT = `SPMSFP_RST_STAT;

    reg         en_ff;
    reg         sidl_ff;
    reg         ovf_ff;
    reg         txfull_ff;
    reg         rxfull_ff;
    reg  [15:0] con1_ff;
    reg  [15:0] con2_ff;
    reg  [15:0] txbuf_ff;
    reg  [15:0] rxbuf_ff;
    reg  [15:0] sr_ff;
    reg         samp_ff;
    reg  [4:0]  cnt_ff;
    reg  [1:0]  state_ff;
    reg         ph_ff;
    reg         sck_act_ff;
    reg         fs_ff;
    reg         skip_ff;
    reg         sck_prev_ff;
    reg         rdy_ff;
    reg  [31:0] prdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Control fields
    wire       cpd   = con1_ff[`SPMSFP_CON1_CPD];
    wire       opd   = con1_ff[`SPMSFP_CON1_OPD];
    wire       word  = con1_ff[`SPMSFP_CON1_WORD];
    wire       input_sample_phase   = con1_ff[`SPMSFP_CON1_SMP];
    wire       cke   = con1_ff[`SPMSFP_CON1_CKE];
    wire       select_enable  = con1_ff[`SPMSFP_CON1_SELECT_ENABLE];
    wire       cpol  = con1_ff[`SPMSFP_CON1_CPOL];
    wire       mst   = con1_ff[`SPMSFP_CON1_MST];
    wire       frm   = con2_ff[`SPMSFP_CON2_FRM];
    wire       fsd   = con2_ff[`SPMSFP_CON2_FSD];
    wire       fpol  = con2_ff[`SPMSFP_CON2_FPOL];
    wire       fdly  = con2_ff[`SPMSFP_CON2_FDLY];

    wire [4:0] nbits   = word ? `SPMSFP_BITS_WORD : `SPMSFP_BITS_BYTE;
    // Clock edge select has no meaning in framed mode
    wire       cke_eff = cke & ~frm;
    wire       run     = en_ff & ~(sidl_ff & device_idle);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin inputs
    wire [2:0] pins_s;
    wire       sck_s = pins_s[2];
    wire       sdi_s = pins_s[1];
    wire       ss_s  = pins_s[0];

    spmsfp_pinsync #(
        .WIDTH   (3),
        .RST_VAL (3'h1)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   ({shift_clock_pin_i, serial_in_pin, select_pin_n_i}),
        .pin_s   (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Master bit clock; a disabled internal clock freezes the master engine
    wire tick;
    wire m_clk_run = run & mst & ~cpd & (state_ff != ST_IDLE);

    spmsfp_baud u_baud (
        .pclk               (pclk),
        .presetn            (presetn),
        .run                (m_clk_run),
        .primary_prescale   (con1_ff[1:0]),
        .secondary_prescale (con1_ff[4:2]),
        .tick               (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Edge events: lead is idle-to-active, trail is active-to-idle
    wire in_shift  = run & (state_ff == ST_SHIFT);
    wire ss_gate   = ~select_enable | ~ss_s;
    wire fs_in_act = (ss_s == fpol);
    wire s_edge    = in_shift & ~mst & (sck_s != sck_prev_ff);
    wire s_lead    = s_edge & (sck_s != cpol);
    wire s_trail   = s_edge & (sck_s == cpol);
    wire m_lead    = in_shift & mst & tick & ~ph_ff;
    wire m_trail   = in_shift & mst & tick & ph_ff;
    wire lead      = mst ? m_lead  : (s_lead & ~skip_ff);
    wire trail     = mst ? m_trail : (s_trail & ~skip_ff);

    wire chg_ev    = cke_eff ? trail : lead;
    wire smp_ev    = cke_eff ? lead : trail;
    // End-of-bit sampling takes the pin at the change edge itself
    wire in_bit    = (mst & input_sample_phase) ? sdi_s : samp_ff;
    wire done_ev   = cke_eff ? (chg_ev & (cnt_ff == nbits))
                             : (smp_ev & (cnt_ff == nbits - 5'h01));
    wire [15:0] result  = {sr_ff[14:0], cke_eff ? in_bit : sdi_s};
    wire [15:0] rx_word = word ? result : {8'h00, result[7:0]};

    wire m_load = run & mst & (state_ff == ST_IDLE) & txfull_ff;
    wire s_load = run & ~mst & txfull_ff & (cnt_ff == 5'h00)
                & (state_ff != ST_PRE) & ~s_edge;
    wire tx_load = m_load | s_load;

    ////////////////////////////////////////////////////////////////////////////////
    // APB access, one wait state so read data comes from a flop
    wire acc_en  = psel & penable;
    wire done_ap = acc_en & rdy_ff;
    wire sel_st  = (paddr == `SPMSFP_OFF_STAT);
    wire sel_c1  = (paddr == `SPMSFP_OFF_CON1);
    wire sel_c2  = (paddr == `SPMSFP_OFF_CON2);
    wire sel_buf = (paddr == `SPMSFP_OFF_BUF);
    wire hit     = sel_st | sel_c1 | sel_c2 | sel_buf;
    wire wr_st   = done_ap & pwrite & sel_st;
    wire buf_wr  = done_ap & pwrite & sel_buf;
    wire buf_rd  = done_ap & ~pwrite & sel_buf;
    wire rx_take = done_ev & (~rxfull_ff | buf_rd);

    wire [15:0] stat_rd = {en_ff, 1'b0, sidl_ff, 6'h00, ovf_ff, 4'h0,
                           txfull_ff, rxfull_ff};

    assign pready  = rdy_ff;
    assign pslverr = rdy_ff & ~hit;
    assign prdata  = prdata_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_ff    <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            rdy_ff <= acc_en & ~rdy_ff;
            if (acc_en & ~rdy_ff) begin
                prdata_ff <= 32'h0000_0000;
                if (sel_st) begin
                    prdata_ff <= {16'h0000, stat_rd};
                end
                if (sel_c1) begin
                    prdata_ff <= {16'h0000, con1_ff};
                end
                if (sel_c2) begin
                    prdata_ff <= {16'h0000, con2_ff};
                end
                if (sel_buf) begin
                    prdata_ff <= {16'h0000, rxbuf_ff};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and flags; hardware set wins over a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff     <= RST_STAT[`SPMSFP_STAT_EN];
            sidl_ff   <= 1'b0;
            ovf_ff    <= 1'b0;
            txfull_ff <= 1'b0;
            rxfull_ff <= 1'b0;
            con1_ff   <= `SPMSFP_RST_CON1;
            con2_ff   <= `SPMSFP_RST_CON2;
            txbuf_ff  <= `SPMSFP_RST_BUF;
            rxbuf_ff  <= `SPMSFP_RST_BUF;
        end else begin
            if (wr_st) begin
                en_ff   <= pwdata[`SPMSFP_STAT_EN];
                sidl_ff <= pwdata[`SPMSFP_STAT_SIDL];
            end
            if (done_ap & pwrite & sel_c1) begin
                con1_ff <= pwdata[15:0] & `SPMSFP_CON1_MASK;
            end
            if (done_ap & pwrite & sel_c2) begin
                con2_ff <= pwdata[15:0] & `SPMSFP_CON2_MASK;
            end
            if (done_ev & rxfull_ff & ~buf_rd) begin
                ovf_ff <= 1'b1;
            end else if (wr_st & ~pwdata[`SPMSFP_STAT_OVF]) begin
                ovf_ff <= 1'b0;
            end
            if (buf_wr) begin
                txbuf_ff  <= pwdata[15:0];
                txfull_ff <= 1'b1;
            end else if (tx_load) begin
                txfull_ff <= 1'b0;
            end
            if (rx_take) begin
                rxbuf_ff  <= rx_word;
                rxfull_ff <= 1'b1;
            end else if (buf_rd) begin
                rxfull_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_ff       <= 16'h0000;
            samp_ff     <= 1'b0;
            cnt_ff      <= 5'h00;
            state_ff    <= ST_IDLE;
            ph_ff       <= 1'b0;
            sck_act_ff  <= 1'b0;
            fs_ff       <= 1'b0;
            skip_ff     <= 1'b0;
            sck_prev_ff <= 1'b0;
        end else if (!en_ff) begin
            cnt_ff      <= 5'h00;
            state_ff    <= ST_IDLE;
            ph_ff       <= 1'b0;
            sck_act_ff  <= 1'b0;
            fs_ff       <= 1'b0;
            skip_ff     <= 1'b0;
            sck_prev_ff <= cpol;
        end else if (run) begin
            sck_prev_ff <= sck_s;
            if (tx_load) begin
                sr_ff <= txbuf_ff;
            end
            case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= 5'h00;
                    ph_ff  <= 1'b0;
                    if (mst) begin
                        if (txfull_ff) begin
                            if (frm & ~fsd) begin
                                fs_ff    <= 1'b1;
                                state_ff <= fdly ? ST_SHIFT : ST_PRE;
                            end else begin
                                state_ff <= ST_SHIFT;
                            end
                        end
                    end else if (frm) begin
                        if (fsd & fs_in_act) begin
                            state_ff <= ST_SHIFT;
                            skip_ff  <= ~fdly;
                        end
                    end else if (ss_gate) begin
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_PRE: begin
                    // Sync pulse spans one bit time with the clock held idle
                    if (tick & ~cpd) begin
                        ph_ff <= ~ph_ff;
                        if (ph_ff) begin
                            fs_ff    <= 1'b0;
                            state_ff <= ST_SHIFT;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (~mst & ~frm & ~ss_gate) begin
                        // Deselect aborts a partial word
                        cnt_ff   <= 5'h00;
                        state_ff <= ST_IDLE;
                    end else begin
                        if (m_lead | m_trail) begin
                            ph_ff      <= ~ph_ff;
                            sck_act_ff <= ~ph_ff;
                            if (ph_ff) begin
                                fs_ff <= 1'b0;
                            end
                        end
                        if (skip_ff & s_trail) begin
                            skip_ff <= 1'b0;
                        end
                        if (smp_ev) begin
                            samp_ff <= sdi_s;
                            cnt_ff  <= cnt_ff + 5'h01;
                        end
                        if (chg_ev & (cnt_ff != 5'h00)) begin
                            sr_ff <= {sr_ff[14:0], in_bit};
                        end
                        if (done_ev) begin
                            sr_ff  <= result;
                            cnt_ff <= 5'h00;
                            if (mst | frm) begin
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive; output bit is the top of the active word, MSB first
    assign shift_clock_pin_o  = sck_act_ff ^ cpol;
    assign shift_clock_pin_oe = en_ff & mst & ~cpd;
    assign serial_out_pin_o   = word ? sr_ff[15] : sr_ff[7];
    assign serial_out_pin_oe  = en_ff & ~opd & (mst | frm | ss_gate);
    assign select_pin_n_o     = fs_ff ? fpol : ~fpol;
    assign select_pin_n_oe    = en_ff & frm & ~fsd;

endmodule // spmsfp_top

// ---- hw/spmsfp_defines.vh ----
// Register map, field positions, reset values and divider encodings of the serial port
`ifndef SPMSFP_DEFINES_VH
`define SPMSFP_DEFINES_VH

// Register byte offsets
`define SPMSFP_OFF_STAT      12'h000
`define SPMSFP_OFF_CON1      12'h004
`define SPMSFP_OFF_CON2      12'h008
`define SPMSFP_OFF_BUF       12'h00c

// Status and control fields
`define SPMSFP_STAT_EN       15
`define SPMSFP_STAT_SIDL     13
`define SPMSFP_STAT_OVF      6
`define SPMSFP_STAT_TBF      1
`define SPMSFP_STAT_RBF      0

// Control one fields
`define SPMSFP_CON1_CPD      12
`define SPMSFP_CON1_OPD      11
`define SPMSFP_CON1_WORD     10
`define SPMSFP_CON1_SMP      9
`define SPMSFP_CON1_CKE      8
`define SPMSFP_CON1_SELECT_ENABLE     7
`define SPMSFP_CON1_CPOL     6
`define SPMSFP_CON1_MST      5
`define SPMSFP_CON1_MASK     16'h1fff

// Control two fields
`define SPMSFP_CON2_FRM      15
`define SPMSFP_CON2_FSD      14
`define SPMSFP_CON2_FPOL     13
`define SPMSFP_CON2_FDLY     1
`define SPMSFP_CON2_MASK     16'he002

// Reset values
`define SPMSFP_RST_STAT      16'h0000
`define SPMSFP_RST_CON1      16'h0000
`define SPMSFP_RST_CON2      16'h0000
`define SPMSFP_RST_BUF       16'h0000

// Primary divider per code 00..11, secondary divider is 8 minus code
`define SPMSFP_PRI_DIV0      10'h040
`define SPMSFP_PRI_DIV1      10'h010
`define SPMSFP_PRI_DIV2      10'h004
`define SPMSFP_PRI_DIV3      10'h001
`define SPMSFP_SEC_BASE      10'h008

// Word lengths in bits
`define SPMSFP_BITS_BYTE     5'h08
`define SPMSFP_BITS_WORD     5'h10

`endif

// ---- hw/spmsfp_pinsync.v ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module spmsfp_pinsync #(
    parameter         WIDTH   = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Pins in, stable values out
    input  wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] pin_s
);

    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;
    reg [WIDTH-1:0] stage3_ff;
    reg [WIDTH-1:0] stable_ff;
    integer         i;

    ////////////////////////////////////////////////////////////////////////////////
    // A change only counts once the second and third stages agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
            stage3_ff <= RST_VAL;
            stable_ff <= RST_VAL;
        end else begin
            stage1_ff <= pin_i;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2_ff[i] == stage3_ff[i]) begin
                    stable_ff[i] <= stage3_ff[i];
                end
            end
        end
    end

    assign pin_s = stable_ff;

endmodule // spmsfp_pinsync

// ---- hw/spmsfp_baud.v ----
// Shift clock divider: one-cycle tick per half bit period
`timescale 1ns/1ps
`include "spmsfp_defines.vh"

module spmsfp_baud (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Control
    input  wire       run,
    input  wire [1:0] primary_prescale,
    input  wire [2:0] secondary_prescale,
    // Half bit tick
    output wire       tick
);

    reg  [9:0] count_ff;
    reg        tick_ff;
    wire [9:0] half_period;

    function [9:0] pri_div;
        input [1:0] code;
        begin
            case (code)
                2'h0:    pri_div = `SPMSFP_PRI_DIV0;
                2'h1:    pri_div = `SPMSFP_PRI_DIV1;
                2'h2:    pri_div = `SPMSFP_PRI_DIV2;
                default: pri_div = `SPMSFP_PRI_DIV3;
            endcase
        end
    endfunction

    // Largest product is 64 times 8, well inside ten bits
    wire [19:0] product = pri_div(primary_prescale)
                        * (`SPMSFP_SEC_BASE - {7'h00, secondary_prescale});
    assign half_period = product[9:0];

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 10'h000;
            tick_ff  <= 1'b0;
        end else if (!run) begin
            count_ff <= 10'h000;
            tick_ff  <= 1'b0;
        end else if (count_ff >= half_period - 10'h001) begin
            count_ff <= 10'h000;
            tick_ff  <= 1'b1;
        end else begin
            count_ff <= count_ff + 10'h001;
            tick_ff  <= 1'b0;
        end
    end

    assign tick = tick_ff;

endmodule // spmsfp_baud

// ---- bench/spmsfp_asserts.sv ----
// Port-level checks of the serial port top
`timescale 1ns/1ps
module spmsfp_asserts (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        device_idle,
    input wire logic        shift_clock_pin_o,
    input wire logic        shift_clock_pin_oe,
    input wire logic        serial_out_pin_o,
    input wire logic        serial_out_pin_oe,
    input wire logic        select_pin_n_oe
);
    logic        en_ff, sidl_ff, sck_ff;
    logic [15:0] c1_ff, c2_ff;
    logic [9:0]  quiet_ff;
    wire         wr = psel & penable & pready & pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // Shadow control bits, taken at the edge the port takes them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_ff, sidl_ff, sck_ff, c1_ff, c2_ff, quiet_ff} <= '0;
        end else begin
            if (wr && paddr == 12'h000) {en_ff, sidl_ff} <= {pwdata[15], pwdata[13]};
            if (wr && paddr == 12'h004) c1_ff <= pwdata[15:0];
            if (wr && paddr == 12'h008) c2_ff <= pwdata[15:0];
            sck_ff <= shift_clock_pin_o;
            quiet_ff <= (sck_ff != shift_clock_pin_o) ? 10'h000 : quiet_ff + {9'h000, ~&quiet_ff};
        end
    end
    property p_off;
        $stable(en_ff) && !en_ff |-> !shift_clock_pin_oe && !serial_out_pin_oe && !select_pin_n_oe;
    endproperty
    a_off: assert property (p_off) else $error("pin driven while off");
    property p_sck_oe;
        $stable({en_ff, c1_ff}) |-> shift_clock_pin_oe == (en_ff & c1_ff[5] & ~c1_ff[12]);
    endproperty
    a_sck_oe: assert property (p_sck_oe) else $error("clock pin enable wrong");
    property p_sdo_off;
        $stable({en_ff, c1_ff}) && c1_ff[11] |-> !serial_out_pin_oe;
    endproperty
    a_sdo_off: assert property (p_sdo_off) else $error("data pin not released");
    property p_fs_oe;
        $stable({en_ff, c2_ff}) |-> select_pin_n_oe == (en_ff & c2_ff[15] & ~c2_ff[14]);
    endproperty
    a_fs_oe: assert property (p_fs_oe) else $error("sync pin enable wrong");
    property p_idle;
        shift_clock_pin_oe && quiet_ff > 10'd520 |-> shift_clock_pin_o == c1_ff[6];
    endproperty
    a_idle: assert property (p_idle) else $error("clock idle level wrong");
    property p_edge;
        en_ff && c1_ff[5] && !c2_ff[15] && $changed(serial_out_pin_o) && $changed(shift_clock_pin_o)
            |-> (shift_clock_pin_o == c1_ff[6]) == c1_ff[8];
    endproperty
    a_edge: assert property (p_edge) else $error("data changed on wrong edge");
    property p_sidl;
        en_ff && sidl_ff && device_idle && $past(device_idle, 4)
            |-> $stable(shift_clock_pin_o) && $stable(serial_out_pin_o);
    endproperty
    a_sidl: assert property (p_sidl) else $error("port ran while idle");
    property p_rsvd;
        pready && !pwrite && paddr == 12'h000 |-> (prdata & 32'hffff5fbc) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
    property p_unm;
        pready && paddr[11:4] != 8'h00 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped access not refused");
    c_buf: cover property (wr && paddr == 12'h00c);
    c_err: cover property (pslverr);
    c_sidl: cover property (en_ff && sidl_ff && device_idle && shift_clock_pin_oe);
endmodule // spmsfp_asserts

bind spmsfp_top spmsfp_asserts u_spmsfp_asserts (.*);

// ---- bench/spmsfp_partner.sv ----
// Far-side peripheral: returns a word while capturing ours
`timescale 1ns/1ps
module spmsfp_partner (
    // Link
    input  wire logic        sck,
    input  wire logic        mosi,
    output logic             miso,
    // Bench side
    input  wire logic        arm,
    input  wire logic        wide,
    input  wire logic [15:0] tx_word,
    output logic [15:0]      rx_word
);
    logic [3:0] cnt_ff;
    // Idle-low clock: capture on the rising edge
    always @(posedge sck or posedge arm) begin
        if (arm) cnt_ff <= 4'h0;
        else begin
            rx_word <= {rx_word[14:0], mosi};
            cnt_ff  <= cnt_ff + 4'h1;
        end
    end
    // Change on the falling edge so the bit is settled when sampled
    always @(negedge sck or posedge arm) begin
        miso <= tx_word[(wide ? 4'hf : 4'h7) - (arm ? 4'h0 : cnt_ff)];
    end
endmodule // spmsfp_partner

// ---- bench/tb.sv ----
// Bench for the serial port top against the peripheral model
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, device_idle, arm, wide;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd_q;
    logic [15:0] tx_word;
    wire  [31:0] prdata;
    wire  [15:0] rx_word;
    wire         pready, pslverr, sck_o, sck_oe, sdo, sdo_oe, ss_o, ss_oe, miso;
    int          miscompares, samples_checked;
    // Clock line stands still while nobody drives it
    wire         sck = sck_oe ? sck_o : 1'b0;
    spmsfp_top u_spmsfp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .device_idle(device_idle), .shift_clock_pin_i(sck),
        .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .serial_in_pin(miso),
        .serial_out_pin_o(sdo), .serial_out_pin_oe(sdo_oe), .select_pin_n_i(1'b1),
        .select_pin_n_o(ss_o), .select_pin_n_oe(ss_oe));
    spmsfp_partner u_spmsfp_partner (.sck(sck), .mosi(sdo), .miso(miso), .arm(arm),
        .wide(wide), .tx_word(tx_word), .rx_word(rx_word));
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_q = prdata;
        {psel, penable} <= 2'b00;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask
    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_q & m, e);
    endtask
    task automatic wait_bit(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h000, 32'h0);
            n++;
        end while ((rd_q & m) == 32'h0 && n < 300);
        chk(rd_q & m, m);
    endtask
    task automatic arm_tx(input logic [15:0] t);
        tx_word <= t;
        arm <= 1'b1;
        @(posedge pclk);
        arm <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end
    initial begin
        {presetn, device_idle, arm, wide, tx_word} = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rdm(12'(i * 4), 32'hffffffff, 32'h0);
        apb(1'b1, 12'h008, 32'hffff);
        rdm(12'h008, 32'hffffffff, 32'he002);
        apb(1'b1, 12'h008, 32'h0);
        $display("registers done");
        apb(1'b1, 12'h004, 32'h013a);
        apb(1'b1, 12'h00c, 32'h00a5);
        rdm(12'h000, 32'h3, 32'h2);
        arm_tx(16'h003c);
        apb(1'b1, 12'h000, 32'h8000);
        wait_bit(32'h1);
        rdm(12'h000, 32'h3, 32'h1);
        chk({24'h0, rx_word[7:0]}, 32'ha5);
        rdm(12'h00c, 32'hffffffff, 32'h3c);
        rdm(12'h000, 32'h1, 32'h0);
        $display("byte transfer done");
        arm_tx(16'h0081);
        apb(1'b1, 12'h00c, 32'h000f);
        wait_bit(32'h1);
        arm_tx(16'h0042);
        apb(1'b1, 12'h00c, 32'h00f0);
        wait_bit(32'h40);
        rdm(12'h00c, 32'hffffffff, 32'h81);
        apb(1'b1, 12'h000, 32'h8000);
        rdm(12'h000, 32'h41, 32'h0);
        $display("overflow done");
        wide <= 1'b1;
        arm_tx(16'hbeef);
        apb(1'b1, 12'h004, 32'h073a);
        apb(1'b1, 12'h000, 32'ha000);
        apb(1'b1, 12'h00c, 32'h1234);
        device_idle <= 1'b1;
        repeat (300) @(posedge pclk);
        rdm(12'h000, 32'h1, 32'h0);
        device_idle <= 1'b0;
        wait_bit(32'h1);
        chk({16'h0, rx_word}, 32'h1234);
        rdm(12'h00c, 32'hffffffff, 32'hbeef);
        $display("word transfer done");
        apb(1'b1, 12'h004, 32'h1d3a);
        @(negedge pclk);
        chk({30'h0, sck_oe, sdo_oe}, 32'h0);
        apb(1'b1, 12'h004, 32'h047a);
        apb(1'b1, 12'h008, 32'ha000);
        repeat (600) @(posedge pclk);
        @(negedge pclk);
        chk({29'h0, sck_o, ss_oe, ss_o}, 32'h6);
        apb(1'b1, 12'h000, 32'h0);
        @(negedge pclk);
        chk({29'h0, sck_oe, sdo_oe, ss_oe}, 32'h0);
        $display("pin control done");
        print_verdict();
    end
endmodule // tb
